/* File: rtl/pds_pkg.sv */
// package for the panel display status select block
package pds_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] PDS_OFS_SEL    = 8'h00;
  localparam logic [7:0] PDS_OFS_ACTIVE = 8'h04;
  localparam logic [7:0] PDS_OFS_CFG    = 8'h08;
  localparam logic [7:0] PDS_OFS_STATUS = 8'h0c;
  localparam logic [5:0] PDS_SEL_RESET  = 6'h22;
  localparam logic [5:0] PDS_SEL_MAX    = 6'h2a;
  // cfg fields
  localparam int PDS_CFG_OT    = 0;
  localparam int PDS_CFG_INH   = 1;
  localparam int PDS_CFG_CLR   = 2;
  localparam int PDS_CFG_ZC    = 3;
  localparam int PDS_CFG_FBUS  = 4;
  localparam logic [4:0] PDS_CFG_RESET = 5'h00;
  // ------------------------------------------------------------
  // selections and reason codes
  // ------------------------------------------------------------
  localparam logic [5:0] PDS_SEL_DEVIATION = 6'h00;
  localparam logic [5:0] PDS_SEL_SPEED     = 6'h01;
  localparam logic [5:0] PDS_SEL_PEAK_TRQ  = 6'h07;
  localparam logic [5:0] PDS_SEL_HISTORY   = 6'h0c;
  localparam logic [5:0] PDS_SEL_ALARM     = 6'h0d;
  localparam logic [5:0] PDS_SEL_ENC_DEV   = 6'h18;
  localparam logic [5:0] PDS_SEL_SERVO_ST  = 6'h22;
  localparam logic [5:0] PDS_SEL_SYNC_PER  = 6'h24;
  localparam logic [5:0] PDS_SEL_DC_RUN    = 6'h27;
  localparam logic [5:0] PDS_SEL_SUBIDX    = 6'h29;
  localparam logic [4:0] PDS_RC_NORMAL   = 5'h00;
  localparam logic [4:0] PDS_RC_UNDERV   = 5'h01;
  localparam logic [4:0] PDS_RC_SRVON    = 5'h02;
  localparam logic [4:0] PDS_RC_OVERTRV  = 5'h03;
  localparam logic [4:0] PDS_RC_RELAY    = 5'h05;
  localparam logic [4:0] PDS_RC_INHIBIT  = 5'h06;
  localparam logic [4:0] PDS_RC_CLEAR    = 5'h08;
  localparam logic [4:0] PDS_RC_ZCLAMP   = 5'h09;
  localparam logic [4:0] PDS_RC_TRQLIM   = 5'h0c;
  localparam logic [4:0] PDS_RC_BUSSTOP  = 5'h0d;
  localparam logic [4:0] PDS_RC_SYNC     = 5'h0e;
  localparam logic [4:0] PDS_RC_PVSTART  = 5'h0f;
  localparam logic [4:0] PDS_RC_DUALEN   = 5'h10;
  localparam logic [4:0] PDS_RC_HOMEMODE = 5'h11;
  localparam logic [4:0] PDS_RC_DCOFF    = 5'h14;
  localparam logic [4:0] PDS_RC_HOMEERR  = 5'h15;
  localparam logic [4:0] PDS_RC_SWLIM    = 5'h16;
  localparam logic [4:0] PDS_RC_BADMODE  = 5'h17;
  // operation mode encodings
  localparam logic [3:0] PDS_MODE_PV  = 4'h3;
  localparam logic [3:0] PDS_MODE_TQ  = 4'h4;
  localparam logic [3:0] PDS_MODE_CSP = 4'h8;
  localparam logic [3:0] PDS_MODE_CSV = 4'h9;
  localparam logic [3:0] PDS_MODE_CST = 4'ha;
  // AXI answers
  localparam logic [1:0] PDS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PDS_RESP_SLVERR = 2'b10;
  // state machine for the write channel
  typedef enum logic [1:0] {
    PDS_W_IDLE = 2'b00,
    PDS_W_RESP = 2'b01
  } pds_wstate_t;
endpackage

/* File: rtl/pds_top.sv */
// panel display status select: reason encoder, decimal points, power-on selection
module pds_top
  import pds_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins, asynchronous
  input  wire logic        servo_on_input,
  input  wire logic        positive_limit_input,
  input  wire logic        negative_limit_input,
  input  wire logic        pulse_inhibit_input,
  input  wire logic        deviation_clear_input,
  input  wire logic        zero_clamp_input,
  input  wire logic        ext_enable_input,
  // drive status, same clock
  input  wire logic        bus_undervoltage,
  input  wire logic        relay_open,
  input  wire logic        speed_cmd_pos,
  input  wire logic        speed_cmd_neg,
  input  wire logic        torque_limit_small,
  input  wire logic        bus_estop,
  input  wire logic        sync_cycle_bad,
  input  wire logic        pv_start_seen,
  input  wire logic        bus_enable_cmd,
  input  wire logic        homing_id_bad,
  input  wire logic        distributed_clocking,
  input  wire logic        homing_signal_bad,
  input  wire logic        soft_limit_active,
  input  wire logic        mode_unsupported,
  input  wire logic [3:0]  op_mode,
  // value shown on the panel
  input  wire logic        show_high_half,
  input  wire logic        value_negative,
  // outputs
  output logic [4:0]       no_rotation_reason,
  output logic [5:0]       display_select,
  output logic [4:0]       decimal_points
);

  localparam int NPIN = 7;

  // only the three-flop synchroniser is built
  if (SYNC_STAGES != 3) begin : g_sync_check
    $error("SYNC_STAGES must be 3");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pin;
    logic [5:0]      sel;
    logic [5:0]      active;
    logic            loaded;
    logic [4:0]      cfg;
    logic [4:0]      reason;
    logic [4:0]      dp;
    pds_wstate_t     wst;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } pds_state_t;

  pds_state_t st_r;
  pds_state_t st_nxt;

  logic [NPIN-1:0] pins_raw;
  logic [4:0]      code;
  logic            ot_hit;
  logic            wr_go;
  logic            wr_ok;

  assign pins_raw = {ext_enable_input, zero_clamp_input, deviation_clear_input,
                     pulse_inhibit_input, negative_limit_input,
                     positive_limit_input, servo_on_input};

  // ------------------------------------------------------------
  // reason encoder, lowest code wins
  // ------------------------------------------------------------
  // pin bits: 1 means asserted toward common, 0 means open
  assign ot_hit = ~st_r.cfg[PDS_CFG_OT] &
                  ((~st_r.pin[1] & speed_cmd_pos) | (~st_r.pin[2] & speed_cmd_neg));

  always_comb begin
    code = PDS_RC_NORMAL;
    if (mode_unsupported)                           code = PDS_RC_BADMODE;
    if (soft_limit_active)                          code = PDS_RC_SWLIM;
    if (homing_signal_bad)                          code = PDS_RC_HOMEERR;
    if (!distributed_clocking)                      code = PDS_RC_DCOFF;
    if (homing_id_bad)                              code = PDS_RC_HOMEMODE;
    if (st_r.cfg[PDS_CFG_FBUS] && !(st_r.pin[6] && bus_enable_cmd))
                                                    code = PDS_RC_DUALEN;
    if (op_mode == PDS_MODE_PV && !pv_start_seen)   code = PDS_RC_PVSTART;
    if (sync_cycle_bad && (op_mode == PDS_MODE_CSP || op_mode == PDS_MODE_CSV ||
                           op_mode == PDS_MODE_CST))
                                                    code = PDS_RC_SYNC;
    if (bus_estop)                                  code = PDS_RC_BUSSTOP;
    if (op_mode == PDS_MODE_TQ && torque_limit_small)
                                                    code = PDS_RC_TRQLIM;
    if (st_r.cfg[PDS_CFG_ZC] && !st_r.pin[5])       code = PDS_RC_ZCLAMP;
    if (!st_r.cfg[PDS_CFG_CLR] && st_r.pin[4])      code = PDS_RC_CLEAR;
    if (!st_r.cfg[PDS_CFG_INH] && !st_r.pin[3])     code = PDS_RC_INHIBIT;
    if (relay_open)                                 code = PDS_RC_RELAY;
    if (ot_hit)                                     code = PDS_RC_OVERTRV;
    if (!st_r.pin[0])                               code = PDS_RC_SRVON;
    if (bus_undervoltage)                           code = PDS_RC_UNDERV;
  end

  assign wr_go = st_r.aw_got && st_r.w_got && st_r.wst == PDS_W_IDLE;
  assign wr_ok = st_r.awaddr == PDS_OFS_SEL || st_r.awaddr == PDS_OFS_CFG;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // three flops, change taken when stages two and three agree
    st_nxt.s1 = pins_raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < NPIN; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.pin[i] = st_r.s3[i];
      end
    end
    st_nxt.reason = code;
    st_nxt.dp = {{2{value_negative}}, 1'b0, {2{show_high_half}}};
    // active selection latched once after reset only
    if (!st_r.loaded) begin
      st_nxt.active = st_r.sel;
      st_nxt.loaded = 1'b1;
    end
    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    case (st_r.wst)
      PDS_W_IDLE: begin
        if (wr_go) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.wst    = PDS_W_RESP;
          st_nxt.bresp  = wr_ok ? PDS_RESP_OKAY : PDS_RESP_SLVERR;
          if (st_r.wstrb[0] && st_r.awaddr == PDS_OFS_SEL &&
              st_r.wdata[5:0] <= PDS_SEL_MAX) begin
            st_nxt.sel = st_r.wdata[5:0];
          end
          if (st_r.wstrb[0] && st_r.awaddr == PDS_OFS_CFG) begin
            st_nxt.cfg = st_r.wdata[4:0];
          end
        end
      end
      PDS_W_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wst = PDS_W_IDLE;
        end
      end
      default: st_nxt.wst = PDS_W_IDLE;
    endcase
    // read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = PDS_RESP_OKAY;
      case (s_axi_araddr)
        PDS_OFS_SEL:    st_nxt.rdata = {26'h0, st_r.sel};
        PDS_OFS_ACTIVE: st_nxt.rdata = {26'h0, st_r.active};
        PDS_OFS_CFG:    st_nxt.rdata = {27'h0, st_r.cfg};
        PDS_OFS_STATUS: st_nxt.rdata = {20'h0, st_r.pin, st_r.reason};
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = PDS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= '0;
      // sel has no backup store: a write is lost at the next reset, so the
      // selection in force after power-up is always the reset value
      st_r.sel    <= PDS_SEL_RESET;
      st_r.active <= PDS_SEL_RESET;
      st_r.cfg    <= PDS_CFG_RESET;
      st_r.wst    <= PDS_W_IDLE;
      st_r.bresp  <= PDS_RESP_OKAY;
      st_r.rresp  <= PDS_RESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready      = !st_r.aw_got && st_r.wst == PDS_W_IDLE;
  assign s_axi_wready       = !st_r.w_got && st_r.wst == PDS_W_IDLE;
  assign s_axi_bvalid       = st_r.wst == PDS_W_RESP;
  assign s_axi_bresp        = st_r.bresp;
  assign s_axi_arready      = !st_r.rvalid;
  assign s_axi_rvalid       = st_r.rvalid;
  assign s_axi_rdata        = st_r.rdata;
  assign s_axi_rresp        = st_r.rresp;
  assign no_rotation_reason = st_r.reason;
  // selection codes pass straight through; meaning fixed by the package
  assign display_select     = st_r.active;
  assign decimal_points     = st_r.dp;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_high_half_dp: assert property (show_high_half |=> decimal_points[1:0] == 2'b11)
    else $error("high half points wrong");
  chk_low_half_dp: assert property (!show_high_half |=> decimal_points[1:0] == 2'b00)
    else $error("low half points wrong");
  chk_sign_dp: assert property (value_negative |=> decimal_points[4:3] == 2'b11)
    else $error("sign points wrong");
  chk_sel_range: assert property (st_r.sel <= PDS_SEL_MAX)
    else $error("selection out of range");
  chk_active_hold: assert property (st_r.loaded |=> $stable(display_select))
    else $error("display selection changed after power-up");
  chk_undervolt_code: assert property (bus_undervoltage |=> no_rotation_reason == PDS_RC_UNDERV)
    else $error("undervoltage code wrong");
  chk_srvon_code: assert property (!bus_undervoltage && !st_r.pin[0]
                                   |=> no_rotation_reason == PDS_RC_SRVON)
    else $error("servo-on code wrong");
  chk_estop_code: assert property (code == PDS_RC_BUSSTOP |-> bus_estop)
    else $error("bus stop code without cause");
  chk_normal_code: assert property (no_rotation_reason == PDS_RC_NORMAL
                                    && $past(aresetn)
                                    |-> $past(distributed_clocking))
    else $error("normal code without distributed clocking");
  chk_relay_code: assert property (relay_open && !bus_undervoltage && st_r.pin[0] && !ot_hit
                                   |=> no_rotation_reason == PDS_RC_RELAY)
    else $error("relay code wrong");

  cov_undervolt: cover property (no_rotation_reason == PDS_RC_UNDERV);
  cov_normal: cover property (no_rotation_reason == PDS_RC_NORMAL);
  cov_sel_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == PDS_RESP_OKAY);
  cov_negative_high: cover property (decimal_points == 5'h1b);
  cov_dual_enable: cover property (no_rotation_reason == PDS_RC_DUALEN);

endmodule // pds_top

/* File: verif/pds_master_model.sv */
// fieldbus master model: drives the bus enable and clock-sync status
module pds_master_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // scenario requests from the bench
  input  wire logic dc_req,
  input  wire logic ben_req,
  // status seen by the drive
  output logic      distributed_clocking,
  output logic      bus_enable_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // a master that is still booting has neither sync nor enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      distributed_clocking <= 1'b0;
      bus_enable_cmd       <= 1'b0;
    end else begin
      distributed_clocking <= dc_req;
      bus_enable_cmd       <= ben_req;
    end
  end
endmodule // pds_master_model

/* File: verif/testbench.sv */
// self-checking bench for the panel display status select block
module testbench;
  import pds_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // stimulus table
  // ------------------------------------------------------------
  typedef struct packed {
    logic [24:0] m;
    logic [3:0]  op;
    logic [4:0]  cfg;
    logic [4:0]  rc;
  } pds_case_t;
  // bit order: pins, status, dc, bus enable, op_mode; all pins closed except deviation clear and zero clamp, which are open
  localparam logic [24:0] BASE = 25'h038404f;
  localparam pds_case_t CASES [33] = '{
    {25'h80,4'h1,5'h00,5'h01}, {25'h1,4'h1,5'h00,5'h02}, {25'h202,4'h1,5'h00,5'h03},
    {25'h404,4'h1,5'h00,5'h03}, {25'h402,4'h1,5'h00,5'h00}, {25'h202,4'h1,5'h01,5'h00},
    {25'h100,4'h1,5'h00,5'h05}, {25'h8,4'h1,5'h00,5'h06}, {25'h8,4'h1,5'h02,5'h00},
    {25'h10,4'h1,5'h00,5'h08}, {25'h10,4'h1,5'h04,5'h00}, {25'h0,4'h1,5'h08,5'h09},
    {25'h20,4'h1,5'h08,5'h00}, {25'h800,4'h4,5'h00,5'h0c}, {25'h800,4'h1,5'h00,5'h00},
    {25'h1000,4'h1,5'h00,5'h0d}, {25'h2000,4'h8,5'h00,5'h0e}, {25'h2000,4'h9,5'h00,5'h0e},
    {25'h2000,4'ha,5'h00,5'h0e}, {25'h2000,4'h1,5'h00,5'h00}, {25'h4000,4'h3,5'h00,5'h0f},
    {25'h100000,4'h1,5'h10,5'h10}, {25'h100000,4'h1,5'h00,5'h00},
    {25'h40,4'h1,5'h10,5'h10}, {25'h8000,4'h1,5'h00,5'h11}, {25'h80000,4'h1,5'h00,5'h14},
    {25'h10000,4'h1,5'h00,5'h15}, {25'h20000,4'h1,5'h00,5'h16},
    {25'h40000,4'h1,5'h00,5'h17}, {25'h81,4'h1,5'h00,5'h01}, {25'h21000,4'h1,5'h00,5'h0d},
    {25'h302,4'h1,5'h00,5'h03}, {25'h0,4'h1,5'h00,5'h00}};
  localparam logic [5:0] SELS [10] = '{6'h00, 6'h01, 6'h07, 6'h0c, 6'h0d, 6'h18, 6'h24,
                                       6'h27, 6'h29, 6'h2a};
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [1:0]  dp_in = 2'b00;
  logic [31:0] s_axi_rdata, rd;
  logic [24:0] stim = BASE;
  logic [24:0] v;
  logic [4:0]  reason, dps;
  logic [5:0]  dsel;
  logic        dc_w, ben_w;
  int          bad_count = 0;
  int          compares = 0;

  initial forever #50 aclk = ~aclk;

  pds_top DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .servo_on_input(stim[0]), .positive_limit_input(stim[1]),
    .negative_limit_input(stim[2]), .pulse_inhibit_input(stim[3]),
    .deviation_clear_input(stim[4]), .zero_clamp_input(stim[5]),
    .ext_enable_input(stim[6]), .bus_undervoltage(stim[7]), .relay_open(stim[8]),
    .speed_cmd_pos(stim[9]), .speed_cmd_neg(stim[10]), .torque_limit_small(stim[11]),
    .bus_estop(stim[12]), .sync_cycle_bad(stim[13]), .pv_start_seen(stim[14]),
    .bus_enable_cmd(ben_w), .homing_id_bad(stim[15]), .distributed_clocking(dc_w),
    .homing_signal_bad(stim[16]), .soft_limit_active(stim[17]),
    .mode_unsupported(stim[18]), .op_mode(stim[24:21]), .show_high_half(dp_in[0]),
    .value_negative(dp_in[1]), .no_rotation_reason(reason), .display_select(dsel),
    .decimal_points(dps));

  pds_master_model u_master (.aclk(aclk), .aresetn(aresetn), .dc_req(stim[19]),
    .ben_req(stim[20]), .distributed_clocking(dc_w), .bus_enable_cmd(ben_w));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ready is settled by the falling edge, so sampling there avoids races
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap, wp, ta, tw;
    ap = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ap || wp) begin
      @(negedge aclk);
      ta = ap && (s_axi_awready === 1'b1);
      tw = wp && (s_axi_wready === 1'b1);
      @(posedge aclk);
      ap = ap && !ta;
      wp = wp && !tw;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    @(posedge aclk);
    do_reset();
    axr(PDS_OFS_ACTIVE, rd, rsp);
    cmp("active", PDS_SEL_RESET, rd[5:0]);
    axr(8'h10, rd, rsp);
    cmp("unmapped rresp", PDS_RESP_SLVERR, rsp);
    cmp("unmapped rdata", 32'h0, rd);
    axw(8'h10, 32'h5, rsp);
    cmp("unmapped bresp", PDS_RESP_SLVERR, rsp);
    for (int i = 0; i < 10; i++) begin
      axw(PDS_OFS_SEL, {26'h0, SELS[i]}, rsp);
      cmp("sel bresp", PDS_RESP_OKAY, rsp);
      axr(PDS_OFS_SEL, rd, rsp);
      cmp("sel", SELS[i], rd[5:0]);
    end
    axw(PDS_OFS_SEL, 32'h2b, rsp);
    axr(PDS_OFS_SEL, rd, rsp);
    cmp("sel above range", PDS_SEL_MAX, rd[5:0]);
    axr(PDS_OFS_ACTIVE, rd, rsp);
    cmp("active after write", PDS_SEL_SERVO_ST, rd[5:0]);
    @(negedge aclk);
    cmp("display select", PDS_SEL_SERVO_ST, dsel);
    @(posedge aclk);
    do_reset();
    axr(PDS_OFS_SEL, rd, rsp);
    cmp("sel after power cycle", PDS_SEL_RESET, rd[5:0]);
    for (int i = 0; i < 4; i++) begin
      dp_in <= i[1:0];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      cmp("decimal points", {i[1], i[1], 1'b0, i[0], i[0]}, dps);
      @(posedge aclk);
    end
    for (int i = 0; i < 33; i++) begin
      axw(PDS_OFS_CFG, {27'h0, CASES[i].cfg}, rsp);
      v = BASE ^ CASES[i].m;
      v[24:21] = CASES[i].op;
      stim <= v;
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      cmp("reason", CASES[i].rc, reason);
      @(posedge aclk);
      axr(PDS_OFS_STATUS, rd, rsp);
      cmp("status reason", CASES[i].rc, rd[4:0]);
    end
    stop_test();
  end

  // the tests need well under three thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    stop_test();
  end
endmodule // testbench
